// ### rtl/cm_pkg.sv
// Purpose: constants for the core operating mode register bank
// Assumes: one core clock, active-low asynchronous reset
// Notes:   only the low sixteen bits of the register live in this bank
package cm_pkg;

    // ------------------------------------------------------------
    // register layout
    // ------------------------------------------------------------
    localparam int          CM_OPM_W          = 24;
    localparam int          CM_LOW_W          = 16;
    localparam int          CM_BIT_TRACE      = 15;
    localparam int          CM_BIT_ATTR_OFF   = 14;
    localparam int          CM_BIT_ASYNC      = 13;
    localparam int          CM_BIT_SLOW_REL   = 12;
    localparam int          CM_BIT_ACK_SYNC   = 11;
    localparam int          CM_BIT_BURST      = 10;
    localparam int          CM_BIT_PRIO_HI    = 9;
    localparam int          CM_BIT_PRIO_LO    = 8;
    localparam int          CM_BIT_SWITCH     = 7;
    localparam int          CM_BIT_STOP_SHORT = 6;
    localparam int          CM_BIT_BUS_OFF    = 4;
    localparam int          CM_BIT_MODE_HI    = 3;
    localparam logic [15:0] CM_OPM_MASK       = 16'hffdf;
    localparam logic [15:0] CM_OPM_RST        = 16'h0300;

    // ------------------------------------------------------------
    // priority codes, counts
    // ------------------------------------------------------------
    localparam logic [1:0]  CM_PRIO_CMP   = 2'h0;
    localparam logic [1:0]  CM_PRIO_DMA   = 2'h1;
    localparam logic [1:0]  CM_PRIO_EQUAL = 2'h2;
    localparam logic [1:0]  CM_PRIO_CORE  = 2'h3;
    localparam int          CM_BURST_WORDS     = 4;
    localparam int          CM_STOP_LONG_CYC   = 131072;
    localparam int          CM_STOP_SHORT_CYC  = 16;
    localparam int          CM_SYNC_STAGES     = 2;

    // ------------------------------------------------------------
    // bus access states, gray along idle-access-release
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CM_IDLE    = 2'h0,
        CM_ACCESS  = 2'h1,
        CM_RELEASE = 2'h3
    } cm_state_type;

endpackage : cm_pkg

// ### rtl/cm_sync.sv
// Purpose: two-flop synchroniser for a group of level inputs
// Assumes: inputs may change at any time relative to core_clk
// Notes:   first stage feeds only the second stage
module cm_sync
    import cm_pkg::*;
#(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         nrst,
    // data
    input  wire logic [W-1:0] d,
    output      logic [W-1:0] q
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= RST_VAL;
            q        <= RST_VAL;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule : cm_sync

// ### rtl/cm_opmode.sv
// Purpose: low sixteen bits of the core operating mode register and the bus
//          behaviour that it steers
// Assumes: pins sampled on core_clk; mode pins steady at reset release
// Notes:   upper stack bits live elsewhere and read as zero here
//
// How it works
// - trace on: internal access addresses appear on the external address pins
// - priority on: attribute lines one-hot, line 3 highest, line 0 lowest
// - priority off: attribute lines pass raw, several active together
// - async arbitration: grant and busy inputs go through two-flop synchronisers
// - fast release: no extra cycle, busy released with the other pins
// - slow release: one extra cycle, busy released last
// - sync select set: transfer acknowledge synchronised inside
// - cache miss fetches one word, or four when burst is on
// - two-bit field, reset 11, chooses core versus dma bus priority
// - memory switch remaps data memory into program RAM, cache stays lowest
// - stop exit waits 128K cycles, or 16 with short delay set
// - mode bits capture mode pins at the first edge after reset release, then writable
// - register changes only at reset, at the mode pin capture just after it, or on explicit write
module cm_opmode
    import cm_pkg::*;
#(
    parameter int ADDR_W    = 24,
    parameter int STOP_LONG = CM_STOP_LONG_CYC
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // register access by core instructions
    input  wire logic              opmode_wr_en,
    input  wire logic [23:0]       opmode_wr_data,
    output      logic [23:0]       opmode_rd_data,
    input  wire logic [3:0]        mode_select_pins,
    // exported mode state
    output      logic [3:0]        chip_mode_bits,
    output      logic              memory_switch,
    // stop exit
    input  wire logic              stop_exit,
    output      logic              stop_wait,
    output      logic              core_resume,
    // access requests
    input  wire logic              core_req,
    input  wire logic [ADDR_W-1:0] core_addr,
    output      logic              core_done,
    input  wire logic              dma_req,
    input  wire logic [ADDR_W-1:0] dma_addr,
    output      logic              dma_done,
    input  wire logic [1:0]        core_priority_status,
    input  wire logic [1:0]        dma_channel_priority,
    input  wire logic              int_access,
    input  wire logic [ADDR_W-1:0] int_addr,
    input  wire logic [3:0]        attr_match,
    // external bus pins
    output      logic [ADDR_W-1:0] ext_addr,
    output      logic              ext_addr_oe_n,
    output      logic [3:0]        address_attribute_lines,
    input  wire logic              bus_grant_in_n,
    input  wire logic              bus_busy_line_in_n,
    output      logic              bus_busy_line_out_n,
    output      logic              bus_busy_line_oe_n,
    input  wire logic              transfer_ack_n
);

    // ------------------------------------------------------------
    // register bank
    // ------------------------------------------------------------
    logic [15:0] opm_reg, opm_next;
    logic        rst_done_reg, rst_done_next;

    always_comb begin
        opm_next      = opm_reg;
        rst_done_next = 1'b1;
        if (opmode_wr_en)
            opm_next = opmode_wr_data[15:0] & CM_OPM_MASK;
        if (!rst_done_reg)
            opm_next[CM_BIT_MODE_HI:0] = mode_select_pins;
    end

    // pins are caught at the first edge after release, not by the reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            opm_reg      <= CM_OPM_RST;
            rst_done_reg <= 1'b0;
        end else begin
            opm_reg      <= opm_next;
            rst_done_reg <= rst_done_next;
        end
    end

    logic       trace_on, attr_off, async_on, slow_rel, ack_sync, burst_on;
    logic       stop_short, bus_off;
    logic [1:0] prio_sel;
    assign trace_on   = opm_reg[CM_BIT_TRACE];
    assign attr_off   = opm_reg[CM_BIT_ATTR_OFF];
    assign async_on   = opm_reg[CM_BIT_ASYNC];
    assign slow_rel   = opm_reg[CM_BIT_SLOW_REL];
    assign ack_sync   = opm_reg[CM_BIT_ACK_SYNC];
    assign burst_on   = opm_reg[CM_BIT_BURST];
    assign prio_sel   = opm_reg[CM_BIT_PRIO_HI:CM_BIT_PRIO_LO];
    assign stop_short = opm_reg[CM_BIT_STOP_SHORT];
    assign bus_off    = opm_reg[CM_BIT_BUS_OFF];

    assign opmode_rd_data = {8'h00, opm_reg};
    assign chip_mode_bits = opm_reg[CM_BIT_MODE_HI:0];
    // decoders downstream remap; cache keeps lowest program addresses
    assign memory_switch  = opm_reg[CM_BIT_SWITCH];

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync_q;
    logic       grant_eff, busy_eff, ack_eff;

    cm_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .d        ({bus_grant_in_n, bus_busy_line_in_n, transfer_ack_n}),
        .q        (sync_q)
    );

    // two extra cycles of latency, the price of skipping setup/hold
    assign grant_eff = async_on ? !sync_q[2] : !bus_grant_in_n;
    assign busy_eff  = async_on ? !sync_q[1] : !bus_busy_line_in_n;
    // deassert edge is assumed synchronous either way
    assign ack_eff   = ack_sync ? !sync_q[0] : !transfer_ack_n;

    // ------------------------------------------------------------
    // external access sequencer
    // ------------------------------------------------------------
    cm_state_type      state_reg, state_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [1:0]        left_reg, left_next;
    logic              dma_own_reg, dma_own_next;
    logic              turn_dma_reg, turn_dma_next;
    logic              can_start, pick_dma, last_word;

    assign can_start = !bus_off && grant_eff && !busy_eff
                       && (core_req || dma_req);
    assign last_word = (left_reg == 2'h0);

    always_comb begin
        case (prio_sel)
            CM_PRIO_CMP:   pick_dma = dma_channel_priority
                                      > core_priority_status;
            CM_PRIO_DMA:   pick_dma = 1'b1;
            CM_PRIO_EQUAL: pick_dma = turn_dma_reg;
            default:      pick_dma = 1'b0;
        endcase
        if (!dma_req)
            pick_dma = 1'b0;
        if (!core_req)
            pick_dma = 1'b1;
    end

    always_comb begin
        state_next    = state_reg;
        addr_next     = addr_reg;
        left_next     = left_reg;
        dma_own_next  = dma_own_reg;
        turn_dma_next = turn_dma_reg;
        case (state_reg)
            CM_IDLE: begin
                if (can_start) begin
                    state_next    = CM_ACCESS;
                    dma_own_next  = pick_dma;
                    turn_dma_next = !pick_dma;
                    addr_next     = pick_dma ? dma_addr : core_addr;
                    left_next     = (!pick_dma && burst_on)
                                  ? 2'(CM_BURST_WORDS - 1) : 2'h0;
                end
            end
            CM_ACCESS: begin
                if (ack_eff) begin
                    if (!last_word) begin
                        left_next = left_reg - 2'h1;
                        addr_next = addr_reg + ADDR_W'(1);
                    end else if (slow_rel) begin
                        state_next = CM_RELEASE;
                    end else begin
                        state_next = CM_IDLE;
                    end
                end
            end
            CM_RELEASE: state_next = CM_IDLE;
            default:    state_next = CM_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= CM_IDLE;
            addr_reg     <= '0;
            left_reg     <= 2'h0;
            dma_own_reg  <= 1'b0;
            turn_dma_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            addr_reg     <= addr_next;
            left_reg     <= left_next;
            dma_own_reg  <= dma_own_next;
            turn_dma_reg <= turn_dma_next;
        end
    end

    assign core_done = (state_reg == CM_ACCESS) && ack_eff && !dma_own_reg;
    assign dma_done  = (state_reg == CM_ACCESS) && ack_eff && dma_own_reg;

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] ext_addr_next;
    logic              addr_oe_n_next, busy_oe_n_next;
    logic [3:0]        attr_raw, attr_next;
    logic              trace_go;

    assign trace_go = trace_on && int_access && grant_eff && !bus_off
                      && (state_next == CM_IDLE);

    always_comb begin
        ext_addr_next  = ext_addr;
        addr_oe_n_next = 1'b1;
        busy_oe_n_next = 1'b1;
        attr_raw       = 4'h0;
        if (state_next == CM_ACCESS) begin
            ext_addr_next  = addr_next;
            addr_oe_n_next = 1'b0;
            busy_oe_n_next = 1'b0;
            attr_raw       = attr_match;
        end else if (state_next == CM_RELEASE) begin
            busy_oe_n_next = 1'b0;
        end else if (trace_go) begin
            ext_addr_next  = int_addr;
            addr_oe_n_next = 1'b0;
        end
        attr_next = attr_raw;
        if (!attr_off) begin
            casez (attr_raw)
                4'b1???: attr_next = 4'h8;
                4'b01??: attr_next = 4'h4;
                4'b001?: attr_next = 4'h2;
                4'b0001: attr_next = 4'h1;
                default: attr_next = 4'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ext_addr                <= '0;
            ext_addr_oe_n           <= 1'b1;
            bus_busy_line_oe_n      <= 1'b1;
            address_attribute_lines <= 4'h0;
        end else begin
            ext_addr                <= ext_addr_next;
            ext_addr_oe_n           <= addr_oe_n_next;
            bus_busy_line_oe_n      <= busy_oe_n_next;
            address_attribute_lines <= attr_next;
        end
    end

    assign bus_busy_line_out_n = 1'b0;

    // ------------------------------------------------------------
    // stop exit delay
    // ------------------------------------------------------------
    logic [17:0] stop_cnt_reg, stop_cnt_next;
    logic        stop_wait_next;

    assign core_resume = stop_wait && (stop_cnt_reg == 18'h1);

    always_comb begin
        stop_cnt_next  = stop_cnt_reg;
        stop_wait_next = stop_wait;
        if (core_resume) begin
            stop_wait_next = 1'b0;
        end else if (stop_wait) begin
            stop_cnt_next = stop_cnt_reg - 18'h1;
        end else if (stop_exit) begin
            stop_wait_next = 1'b1;
            stop_cnt_next  = stop_short ? 18'(CM_STOP_SHORT_CYC)
                                : 18'(STOP_LONG);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stop_cnt_reg <= 18'h0;
            stop_wait    <= 1'b0;
        end else begin
            stop_cnt_reg <= stop_cnt_next;
            stop_wait    <= stop_wait_next;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_last_ack;
        state_reg == CM_ACCESS && ack_eff && last_word;
    endsequence

    AST_TRACE: assert property (trace_go && state_reg == CM_IDLE
        |=> !ext_addr_oe_n && ext_addr == $past(int_addr))
        else $error("trace address not shown");
    AST_ONEHOT: assert property (!attr_off
        |=> $onehot0(address_attribute_lines))
        else $error("attribute lines not one-hot");
    AST_RAW: assert property (attr_off && state_next == CM_ACCESS
        |=> address_attribute_lines == $past(attr_match))
        else $error("attribute lines not passed raw");
    AST_SYNC: assert property (async_on && $past(async_on, 2)
        |-> grant_eff == !$past(bus_grant_in_n, 2))
        else $error("grant not synchronised");
    AST_FAST: assert property (s_last_ack and !slow_rel
        |=> state_reg == CM_IDLE && bus_busy_line_oe_n)
        else $error("fast release wrong");
    AST_SLOW: assert property (s_last_ack and slow_rel
        |=> ext_addr_oe_n && !bus_busy_line_oe_n ##1 bus_busy_line_oe_n)
        else $error("slow release wrong");
    AST_TAS: assert property (ack_sync && $past(ack_sync, 2)
        |-> ack_eff == !$past(transfer_ack_n, 2))
        else $error("acknowledge not synchronised");
    AST_BURST: assert property (state_reg == CM_IDLE && can_start
        && !pick_dma |=> left_reg == ($past(burst_on) ? 2'h3 : 2'h0))
        else $error("burst length wrong");
    AST_CDP: assert property (state_reg == CM_IDLE && can_start
        && core_req && dma_req && prio_sel == CM_PRIO_DMA |=> dma_own_reg)
        else $error("dma priority ignored");
    AST_EBD: assert property (bus_off && state_reg == CM_IDLE
        |=> state_reg == CM_IDLE)
        else $error("access with bus disabled");
    AST_STOP: assert property (stop_exit && stop_short && !stop_wait
        |-> ##16 core_resume)
        else $error("short stop delay wrong");
    AST_MODE: assert property ($rose(rst_done_reg)
        |-> chip_mode_bits == $past(mode_select_pins))
        else $error("mode pins not captured");
    AST_HOLD: assert property (rst_done_reg && !opmode_wr_en
        |=> $stable(opmode_rd_data))
        else $error("register changed without write");
    AST_RESV: assert property (opmode_rd_data[23:16] == 8'h00
        && !opmode_rd_data[5])
        else $error("reserved bits read non-zero");

endmodule : cm_opmode

// ### test/cm_bus_partner.sv
// Purpose: far side of the expansion bus: arbiter, other master, memory
// Assumes: grant and acknowledge move just after the falling edge
// Notes:   busy wire has a pull-up; one ack per word, gap between acks
module cm_bus_partner (
    // clock
    input  wire logic       core_clk,
    // scenario knobs
    input  wire logic       other_busy,
    input  wire logic [3:0] ack_gap,
    // bus pins
    input  wire logic       ext_addr_oe_n,
    input  wire logic       bus_busy_line_out_n,
    input  wire logic       bus_busy_line_oe_n,
    output      logic       bus_grant_in_n,
    output      logic       bus_busy_line_in_n,
    output      logic       transfer_ack_n
);
    timeunit 1ns;
    timeprecision 1ns;
    int gap = 0;
    // released wire floats up through the pull-up
    assign bus_busy_line_in_n = (bus_busy_line_oe_n ? 1'b1 :
                                 bus_busy_line_out_n) & ~other_busy;
    // one device granted at a time, never overlapping
    assign bus_grant_in_n = other_busy;
    initial transfer_ack_n = 1'b1;
    // ack raised and dropped on the clock, held one cycle
    always @(negedge core_clk) begin
        if (ext_addr_oe_n | ~transfer_ack_n) begin
            transfer_ack_n <= 1'b1;
            gap <= int'(ack_gap);
        end else if (gap == 0) begin
            transfer_ack_n <= 1'b0;
        end else begin
            gap <= gap - 1;
        end
    end
endmodule : cm_bus_partner

// ### test/test_core_operating_mode_low_bits.sv
// Purpose: self-checking bench for the operating mode register bank
// Assumes: inputs move at the falling edge, outputs read 5 ns before rise
// Notes:   long stop delay shortened to STOP_T cycles
module test_core_operating_mode_low_bits
    import cm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STOP_T = 40;
    logic        core_clk = 1'b0, nrst = 1'b0, opmode_wr_en = 1'b0;
    logic [23:0] opmode_wr_data = 24'h0, core_addr = 24'h0;
    logic [23:0] dma_addr = 24'h0;
    logic [23:0] int_addr = 24'h0, opmode_rd_data, ext_addr;
    logic [3:0]  mode_select_pins = 4'h0, attr_match = 4'h0, ack_gap = 4'h0;
    logic [3:0]  chip_mode_bits, address_attribute_lines;
    logic [1:0]  core_priority_status = 2'h0, dma_channel_priority = 2'h0;
    logic        stop_exit = 1'b0, core_req = 1'b0, dma_req = 1'b0;
    logic        int_access = 1'b0, other_busy = 1'b0;
    logic        memory_switch, stop_wait, core_resume, core_done, dma_done;
    logic        ext_addr_oe_n, bus_grant_in_n, bus_busy_line_in_n;
    logic        bus_busy_line_out_n, bus_busy_line_oe_n, transfer_ack_n;
    logic [15:0] opm_m;
    // owner of the last access; reset state lets the core win a tie first
    bit          last_dma = 1'b1;
    logic [15:0] cfg [8] = '{16'h0300, 16'h0700, 16'h1300, 16'h0100,
                             16'h0200, 16'h0000, 16'h6b00, 16'h0310};
    integer      seed = 32'h08105c7e;
    int          failures = 0, n_compared = 0;

    always #25 core_clk = ~core_clk;

    cm_opmode #(.STOP_LONG(STOP_T)) dut (.core_clk, .nrst, .opmode_wr_en,
        .opmode_wr_data, .opmode_rd_data, .mode_select_pins, .chip_mode_bits,
        .memory_switch, .stop_exit, .stop_wait, .core_resume, .core_req,
        .core_addr, .core_done, .dma_req, .dma_addr, .dma_done,
        .core_priority_status, .dma_channel_priority, .int_access,
        .int_addr, .attr_match, .ext_addr, .ext_addr_oe_n,
        .address_attribute_lines, .bus_grant_in_n, .bus_busy_line_in_n,
        .bus_busy_line_out_n, .bus_busy_line_oe_n, .transfer_ack_n);
    cm_bus_partner far (.core_clk, .other_busy, .ack_gap, .ext_addr_oe_n,
        .bus_busy_line_out_n, .bus_busy_line_oe_n, .bus_grant_in_n,
        .bus_busy_line_in_n, .transfer_ack_n);

    // ------------------------------------------------------------
    // compare and drive tasks
    // ------------------------------------------------------------
    task automatic check_reg(input string nm, input logic [23:0] e,
                             input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : check_reg

    task automatic check_cnt(input string nm, input int e, input int g);
        n_compared++;
        if (g != e) begin
            failures++;
            $display("mismatch %s expected %0d seen %0d", nm, e, g);
        end
    endtask : check_cnt

    task automatic test_done;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic wr(input logic [23:0] d);
        @(negedge core_clk);
        opmode_wr_en = 1'b1;
        opmode_wr_data = d;
        @(negedge core_clk);
        opmode_wr_en = 1'b0;
        opm_m = d[15:0] & 16'hffdf;
    endtask : wr

    task automatic stop_run(input logic short_on);
        int n;
        wr(short_on ? 24'h000340 : 24'h000300);
        stop_exit = 1'b1;
        @(posedge core_clk);
        n = 0;
        while (n < STOP_T + 20) begin
            @(negedge core_clk);
            stop_exit = 1'b0;
            #20;
            n++;
            if (n == 1) check_reg("stop wait", 24'h1, {23'h0, stop_wait});
            if (core_resume === 1'b1) break;
        end
        check_cnt("stop delay", short_on ? CM_STOP_SHORT_CYC : STOP_T, n);
    endtask : stop_run

    task automatic run_bus(input int i);
        logic [15:0] c;
        logic [3:0]  ea, ga;
        int          nc, nd, ns, nbad, cfirst, acc, alt;
        c = cfg[i];
        alt = int'(last_dma);
        wr({8'h0, c});
        {nc, nd, ns, nbad, cfirst} = '0;
        ga = 4'h0;
        attr_match = 4'($random(seed));
        core_priority_status = 2'($random(seed));
        dma_channel_priority = 2'($random(seed));
        core_addr = 24'($random(seed));
        dma_addr = 24'($random(seed));
        ack_gap = (i == 6) ? 4'h3 : {2'h0, 2'($random(seed))};
        other_busy = (i == 0);
        core_req = 1'b1;
        dma_req = (i >= 2);
        ea = c[14] ? attr_match : attr_match[3] ? 4'h8 : attr_match[2] ?
             4'h4 : attr_match[1] ? 4'h2 : {3'h0, attr_match[0]};
        for (int k = 0; k < 60; k++) begin
            @(negedge core_clk);
            if (k == 8) other_busy = 1'b0;
            if (nc == (c[10] ? 4 : 1)) core_req = 1'b0;
            if (nd == 1) dma_req = 1'b0;
            #20;
            if (other_busy && ext_addr_oe_n === 1'b0) nbad++;
            if (ext_addr_oe_n === 1'b0 && nc + nd == 0) ga = address_attribute_lines;
            if (ext_addr_oe_n === 1'b1 && bus_busy_line_oe_n === 1'b0) ns++;
            if (core_done === 1'b1) begin
                check_reg("core addr", core_addr + 24'(nc), ext_addr);
                if (nd == 0 && nc == 0) cfirst = 1;
                nc++;
                last_dma = 1'b0;
            end
            if (dma_done === 1'b1) begin
                check_reg("dma addr", dma_addr, ext_addr);
                nd++;
                last_dma = 1'b1;
            end
        end
        acc = c[4] ? 0 : 1 + int'(i >= 2);
        check_cnt("core words", c[4] ? 0 : (c[10] ? 4 : 1), nc);
        check_cnt("dma words", acc > 1 ? 1 : 0, nd);
        check_cnt("slow cycles", c[12] ? acc : 0, ns);
        check_cnt("busy refusal", 0, nbad);
        if (!c[4]) check_reg("attr", {20'h0, ea}, {20'h0, ga});
        // equal priority alternates with whoever won the access before
        if (acc > 1) check_cnt("core first", c[9] ? (c[8] ? 1 : alt) :
            c[8] ? 0 :
            int'(!(dma_channel_priority > core_priority_status)), cfirst);
        check_reg("mode kept", {8'h0, opm_m}, opmode_rd_data);
    endtask : run_bus

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        mode_select_pins = 4'($random(seed));
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1'b1;
        opm_m = CM_OPM_RST | {12'h0, mode_select_pins};
        repeat (2) @(negedge core_clk);
        check_reg("reset", {8'h0, opm_m}, opmode_rd_data);
        for (int j = 0; j < 8; j++) begin
            wr(24'($random(seed)));
            check_reg("mode reg", {8'h0, opm_m}, opmode_rd_data);
            check_reg("mode", {20'h0, opm_m[3:0]}, {20'h0, chip_mode_bits});
            check_reg("switch", {23'h0, opm_m[7]}, {23'h0, memory_switch});
            repeat (6) @(negedge core_clk);
        end
        stop_run(1'b1);
        stop_run(1'b0);
        wr(24'h008300);
        int_access = 1'b1;
        int_addr = 24'($random(seed));
        @(negedge core_clk);
        int_access = 1'b0;
        #20;
        check_reg("trace", int_addr, ext_addr);
        check_reg("trace oe", 24'h0, {23'h0, ext_addr_oe_n});
        for (int i = 0; i < 8; i++) run_bus(i);
        test_done;
    end

    // ------------------------------------------------------------
    // watchdog, about eight times the expected run
    // ------------------------------------------------------------
    initial begin
        #250000;
        failures++;
        test_done;
    end
endmodule : test_core_operating_mode_low_bits
